//--- design/dmrb_consts.svh
// constants of the dram mode register bank
`ifndef DMRB_CONSTS_SVH
`define DMRB_CONSTS_SVH
// ---------------------------------------------------------------------
// mode addresses
// ---------------------------------------------------------------------
`define DMRB_MA_DEVINFO 6'h00
`define DMRB_MA_FEATURE 6'h01
`define DMRB_MA_TERMFEAT 6'h0b
`define DMRB_MA_FUNCOPT 6'h0d
`define DMRB_MA_CTRLTERM 6'h16
// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define DMRB_FOPT_WR_BIT 6
`define DMRB_FOPT_OP_BIT 7
`define DMRB_CTRLTERM_CA_BIT 5
`define DMRB_TERMFEAT_CA_HI 6
`define DMRB_TERMFEAT_CA_LO 4
// ---------------------------------------------------------------------
// reset values and encodings
// ---------------------------------------------------------------------
`define DMRB_FEAT_RESET 8'h04
`define DMRB_ZERO_BYTE 8'h00
`define DMRB_BL_16 2'h0
`define DMRB_BL_32 2'h1
`define DMRB_BL_OTF 2'h2
`define DMRB_ZQ_RESISTOR_SELFTEST_RESULT_NONE 2'h0
`define DMRB_ZQ_RESISTOR_SELFTEST_RESULT_OK 2'h3
`define DMRB_NWR_0 6'h06
`define DMRB_NWR_1 6'h0a
`define DMRB_NWR_2 6'h10
`define DMRB_NWR_3 6'h14
`define DMRB_NWR_4 6'h18
`define DMRB_NWR_5 6'h1e
`define DMRB_NWR_6 6'h22
`define DMRB_NWR_7 6'h28
`define DMRB_CYC_ZERO 6'h00
`define DMRB_CYC_ONE 6'h01
// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define DMRB_CLK_PERIOD_NS 5
`define DMRB_ZQLAT_NS 30
`define DMRB_ZQLAT_CYC \
   ((`DMRB_ZQLAT_NS + `DMRB_CLK_PERIOD_NS - 1) / `DMRB_CLK_PERIOD_NS)
`endif

//--- design/dmrb_pkg.sv
// types shared by the dram mode register bank
package dmrb_pkg;
   typedef struct packed {
      logic read_postamble_length;
      logic [2:0] write_recovery_cycles;
      logic rd_pre;
      logic wr_pre;
      logic [1:0] bl;
   } dmrb_feat_s;
   typedef enum logic [1:0] {ZQ_IDLE, ZQ_STARTED, ZQ_LATCH, ZQ_VALID}
      dmrb_zq_e;
   typedef logic [5:0] dmrb_cyc_t;
endpackage : dmrb_pkg

//--- design/dmrb_top.sv
// dram mode register bank: device info and dual set-point features
//
// Overview of operation
// - registers are reached only through mode read and mode write commands.
// - six-bit mode address; device info at 00h, features at 01h.
// - reserved bit positions read back as zero.
// - reserved or write-only reads give undefined data; strobe still toggles.
// - writes to the read-only register change nothing.
// - info bit 0 reports refresh capability.
// - info bit 1 reports latency mode; byte-mode parts set it.
// - info bits 4:3 report the resistor self-test result.
// - result valid after start, latch and latch time; cleared on reset.
// - assembly error forces factory impedance and ignores calibration.
// - info bit 7 set when termination bit 5 and odt code nonzero.
// - feature bits 1:0 pick burst 16, 32 or per command.
// - per-command mode takes burst length from each access command.
// - feature bit 2 sets the 2-cycle write preamble.
// - feature bit 3 picks static or toggling read preamble.
// - feature bits 6:4 encode write recovery 6 to 40 cycles.
// - after an auto-precharge write, wait write recovery then precharge.
// - feature bit 7 picks half or one and a half cycle postamble.
// - writes update only the copy named by the write set-point bit.
// - the device runs from the copy named by the operating bit.
`timescale 1ns/1ps
`include "dmrb_consts.svh"
module dmrb_top import dmrb_pkg::*; #(
   parameter logic REFRESH_MODIFIED_ONLY = 1'b0,
   parameter logic BYTE_MODE_LATENCY = 1'b0
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   // mode register commands
   input wire logic MRW_REQ,
   input wire logic MRR_REQ,
   input wire logic [5:0] MR_ADDR,
   input wire logic [7:0] MRW_DATA,
   // mode register read answer
   output logic RD_VALID,
   output logic [7:0] RD_DATA,
   output logic DQS_TOGGLE,
   // access commands
   input wire logic ACC_REQ,
   input wire logic ACC_BL32,
   input wire logic WR_AP_DONE,
   output logic BURST_32,
   output logic PRECHARGE_START,
   // operating features
   output logic WR_PREAMBLE_2NCK,
   output logic RD_PREAMBLE_TOGGLE,
   output logic RD_POSTAMBLE_LONG,
   // impedance calibration
   input wire logic ZQ_START_DONE,
   input wire logic ZQ_LATCH_DONE,
   input wire logic [1:0] ZQ_SELFTEST_RAW,
   output logic ZQ_CAL_IGNORE,
   output logic FACTORY_TRIM_SEL
);
   localparam int ZQLAT_CYC = `DMRB_ZQLAT_CYC;

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   function automatic logic dmrb_is_ro(input logic [5:0] addr);
      dmrb_is_ro = (addr == `DMRB_MA_DEVINFO);
   endfunction : dmrb_is_ro

   function automatic dmrb_cyc_t dmrb_nwr(input logic [2:0] code);
      unique case (code)
         3'h0: dmrb_nwr = `DMRB_NWR_0;
         3'h1: dmrb_nwr = `DMRB_NWR_1;
         3'h2: dmrb_nwr = `DMRB_NWR_2;
         3'h3: dmrb_nwr = `DMRB_NWR_3;
         3'h4: dmrb_nwr = `DMRB_NWR_4;
         3'h5: dmrb_nwr = `DMRB_NWR_5;
         3'h6: dmrb_nwr = `DMRB_NWR_6;
         3'h7: dmrb_nwr = `DMRB_NWR_7;
      endcase
   endfunction : dmrb_nwr

   // ------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ------------------------------------------------------------------
   // stored mode state
   // ------------------------------------------------------------------
   dmrb_feat_s [1:0] feat_sp;
   logic setpoint_write_select;
   logic setpoint_operate_select;
   logic ctrl_ca_term;
   logic [2:0] ca_odt;
   logic wr_ok;
   dmrb_feat_s feat_op;

   assign wr_ok = MRW_REQ && !dmrb_is_ro(MR_ADDR);
   assign feat_op = feat_sp[setpoint_operate_select];

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         feat_sp <= {`DMRB_FEAT_RESET, `DMRB_FEAT_RESET};
      end else if (wr_ok && MR_ADDR == `DMRB_MA_FEATURE) begin
         feat_sp[setpoint_write_select] <= dmrb_feat_s'(MRW_DATA);
      end
   end

   // only the bits this bank consumes are kept from these registers
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         setpoint_write_select <= 1'b0;
         setpoint_operate_select <= 1'b0;
      end else if (wr_ok && MR_ADDR == `DMRB_MA_FUNCOPT) begin
         setpoint_write_select <= MRW_DATA[`DMRB_FOPT_WR_BIT];
         setpoint_operate_select <= MRW_DATA[`DMRB_FOPT_OP_BIT];
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ca_term <= 1'b0;
         ca_odt <= 3'h0;
      end else if (wr_ok) begin
         if (MR_ADDR == `DMRB_MA_CTRLTERM) begin
            ctrl_ca_term <= MRW_DATA[`DMRB_CTRLTERM_CA_BIT];
         end
         if (MR_ADDR == `DMRB_MA_TERMFEAT) begin
            ca_odt <= MRW_DATA[`DMRB_TERMFEAT_CA_HI:`DMRB_TERMFEAT_CA_LO];
         end
      end
   end

   // ------------------------------------------------------------------
   // impedance self-test sequence
   // ------------------------------------------------------------------
   dmrb_zq_e zq_state;
   logic [7:0] zq_cnt;
   logic [1:0] zq_resistor_selftest_result;
   logic zq_latching;
   logic zq_ignore;

   assign zq_latching = (zq_state == ZQ_LATCH);
   assign zq_ignore = (zq_resistor_selftest_result != `DMRB_ZQ_RESISTOR_SELFTEST_RESULT_NONE) && (zq_resistor_selftest_result != `DMRB_ZQ_RESISTOR_SELFTEST_RESULT_OK);

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         zq_state <= ZQ_IDLE;
         zq_cnt <= 8'h00;
      end else if (!zq_ignore) begin
         unique case (zq_state)
            ZQ_IDLE, ZQ_VALID: begin
               if (ZQ_START_DONE) begin
                  zq_state <= ZQ_STARTED;
               end
            end
            ZQ_STARTED: begin
               if (ZQ_LATCH_DONE) begin
                  zq_state <= ZQ_LATCH;
                  zq_cnt <= 8'(ZQLAT_CYC);
               end
            end
            ZQ_LATCH: begin
               if (zq_cnt == 8'h01) begin
                  zq_state <= ZQ_VALID;
               end
               zq_cnt <= zq_cnt - 8'h01;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         zq_resistor_selftest_result <= `DMRB_ZQ_RESISTOR_SELFTEST_RESULT_NONE;
      end else if (zq_latching && zq_cnt == 8'h01 && !zq_ignore) begin
         zq_resistor_selftest_result <= ZQ_SELFTEST_RAW;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ZQ_CAL_IGNORE <= 1'b0;
         FACTORY_TRIM_SEL <= 1'b0;
      end else begin
         ZQ_CAL_IGNORE <= zq_ignore;
         FACTORY_TRIM_SEL <= zq_ignore;
      end
   end

   // ------------------------------------------------------------------
   // mode register read answer
   // ------------------------------------------------------------------
   logic ca_termination_rank_flag;
   logic [7:0] devinfo;

   assign ca_termination_rank_flag = ctrl_ca_term && (ca_odt != 3'h0);
   assign devinfo = {ca_termination_rank_flag, 2'h0, zq_resistor_selftest_result, 1'h0, BYTE_MODE_LATENCY,
                     REFRESH_MODIFIED_ONLY};

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         RD_VALID <= 1'b0;
         DQS_TOGGLE <= 1'b0;
         RD_DATA <= `DMRB_ZERO_BYTE;
      end else begin
         RD_VALID <= MRR_REQ;
         DQS_TOGGLE <= MRR_REQ;
         if (MRR_REQ) begin
            RD_DATA <= dmrb_is_ro(MR_ADDR) ? devinfo : `DMRB_ZERO_BYTE;
         end
      end
   end

   // ------------------------------------------------------------------
   // operating features
   // ------------------------------------------------------------------
   // write and read preambles, read postamble
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         WR_PREAMBLE_2NCK <= 1'b1;
         RD_PREAMBLE_TOGGLE <= 1'b0;
         RD_POSTAMBLE_LONG <= 1'b0;
      end else begin
         WR_PREAMBLE_2NCK <= feat_op.wr_pre;
         RD_PREAMBLE_TOGGLE <= feat_op.rd_pre;
         RD_POSTAMBLE_LONG <= feat_op.read_postamble_length;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         BURST_32 <= 1'b0;
      end else if (ACC_REQ) begin
         BURST_32 <= (feat_op.bl == `DMRB_BL_32) ||
                     (feat_op.bl == `DMRB_BL_OTF && ACC_BL32);
      end
   end

   // ------------------------------------------------------------------
   // write recovery
   // ------------------------------------------------------------------
   dmrb_wrrec_if wrrec ();

   assign wrrec.load = WR_AP_DONE;
   assign wrrec.cycles = dmrb_nwr(feat_op.write_recovery_cycles);

   dmrb_wrrec u_wrrec (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .wr(wrrec.timer)
   );

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         PRECHARGE_START <= 1'b0;
      end else begin
         PRECHARGE_START <= wrrec.done;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!rst_n);

   AST_RD_ANSWER: assert property (
      MRR_REQ |=> RD_VALID && DQS_TOGGLE)
      else $error("read not answered with strobe");
   AST_RSV_ZERO: assert property (
      MRR_REQ && MR_ADDR == `DMRB_MA_DEVINFO |=>
      RD_DATA[6:5] == 2'h0 && RD_DATA[2] == 1'b0)
      else $error("reserved info bits not zero");
   AST_RO_WRITE: assert property (
      MRW_REQ && MR_ADDR == `DMRB_MA_DEVINFO |=>
      $stable(feat_sp) && $stable(setpoint_operate_select) && $stable(ca_termination_rank_flag))
      else $error("read-only write changed state");
   AST_CA_TERMINATION_RANK_FLAG: assert property (
      MRR_REQ && MR_ADDR == `DMRB_MA_DEVINFO |=>
      RD_DATA[7] == ($past(ctrl_ca_term) && $past(ca_odt) != 3'h0))
      else $error("termination flag wrong");
   AST_SP_WRITE: assert property (
      MRW_REQ && MR_ADDR == `DMRB_MA_FEATURE |=>
      feat_sp[$past(setpoint_write_select)] == $past(MRW_DATA) &&
      feat_sp[!$past(setpoint_write_select)] == $past(feat_sp[!setpoint_write_select]))
      else $error("set-point copy write wrong");
   AST_BL_OTF: assert property (
      ACC_REQ && feat_op.bl == `DMRB_BL_OTF |=> BURST_32 == $past(ACC_BL32))
      else $error("per-command burst ignored");
   AST_NWR6: assert property (
      WR_AP_DONE && feat_op.write_recovery_cycles == 3'h0 ##1 (!WR_AP_DONE)[*6] |->
      $past(PRECHARGE_START) == 1'b0 ##1 PRECHARGE_START)
      else $error("precharge not after 6 cycles");
   AST_ZQ_RESISTOR_SELFTEST_RESULT_SRC: assert property (
      zq_resistor_selftest_result != $past(zq_resistor_selftest_result) |-> $past(zq_latching))
      else $error("self-test result outside latch");
   AST_ZQ_IGN: assert property (
      zq_ignore |=> $stable(zq_state) && ZQ_CAL_IGNORE && FACTORY_TRIM_SEL)
      else $error("calibration not ignored");
   AST_OPERATE: assert property (
      ##1 WR_PREAMBLE_2NCK == $past(feat_sp[setpoint_operate_select].wr_pre))
      else $error("operating copy not used");

   COV_READ_INFO: cover property (
      MRR_REQ && MR_ADDR == `DMRB_MA_DEVINFO ##1 RD_VALID);
   COV_SP1_WRITE: cover property (
      MRW_REQ && MR_ADDR == `DMRB_MA_FEATURE && setpoint_write_select);
   COV_PRECHARGE: cover property (PRECHARGE_START);
   COV_ZQ_VALID: cover property (zq_state == ZQ_VALID);
endmodule : dmrb_top

//--- design/dmrb_wrrec.sv
// write-recovery countdown before internal precharge
`timescale 1ns/1ps
`include "dmrb_consts.svh"
module dmrb_wrrec import dmrb_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control link
   dmrb_wrrec_if.timer wr
);
   dmrb_cyc_t cnt;

   // a new load restarts the wait; back to back bursts share one timer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= `DMRB_CYC_ZERO;
      end else if (wr.load) begin
         cnt <= wr.cycles;
      end else if (cnt != `DMRB_CYC_ZERO) begin
         cnt <= cnt - `DMRB_CYC_ONE;
      end
   end

   assign wr.done = !wr.load && (cnt == `DMRB_CYC_ONE);
endmodule : dmrb_wrrec

//--- design/dmrb_wrrec_if.sv
// link between the bank and its write-recovery timer
`timescale 1ns/1ps
interface dmrb_wrrec_if import dmrb_pkg::*; ();
   logic load;
   dmrb_cyc_t cycles;
   logic done;
   modport ctrl (output load, output cycles, input done);
   modport timer (input load, input cycles, output done);
endinterface : dmrb_wrrec_if

//--- verif/dmrb_ctrl_model.sv
// controller model driving mode register and access commands
`timescale 1ns/1ps
module dmrb_ctrl_model (
   // clock
   input wire logic clk,
   // commands to the device
   output logic mrw_req,
   output logic mrr_req,
   output logic [5:0] mr_addr,
   output logic [7:0] mrw_data,
   output logic acc_req,
   output logic acc_bl32,
   output logic wr_ap_done,
   output logic zq_start_done,
   output logic zq_latch_done,
   output logic [1:0] zq_selftest_raw
);
   // ----------
   // command cycle
   // ----------
   initial begin
      {mrw_req, mrr_req, acc_req, acc_bl32, wr_ap_done} = 5'h00;
      {zq_start_done, zq_latch_done, zq_selftest_raw} = 4'h0;
      mr_addr = 6'h00;
      mrw_data = 8'h00;
   end
   // k bits: write, read, access, ap done, zq start, zq latch
   task automatic cmd(input logic [5:0] k, input logic [5:0] a,
         input logic [7:0] d, input logic b);
      // reads only by command, 29h-2fh never used
      mrr_req = k[1] && !(a inside {[6'h29:6'h2f]});
      // no writes above the mapped range
      mrw_req = k[0] && a < 6'h29;
      mr_addr = a;
      // callers pass reserved bits as zero, except the ffh write to the read-only info register
      mrw_data = d;
      acc_req = k[2];
      acc_bl32 = b;
      wr_ap_done = k[3];
      // start before latch, raw held through latch time
      zq_start_done = k[4];
      zq_latch_done = k[5];
      if (k[5]) begin
         zq_selftest_raw = d[1:0];
      end
      @(posedge clk);
      #1;
   endtask : cmd
   // released lines flip, so a stale value is never mistaken for data
   task automatic idle();
      {mrw_req, mrr_req, acc_req, wr_ap_done} = 4'h0;
      {zq_start_done, zq_latch_done} = 2'h0;
      mr_addr = ~mr_addr;
      mrw_data = ~mrw_data;
      acc_bl32 = ~acc_bl32;
      @(posedge clk);
      #1;
   endtask : idle
endmodule : dmrb_ctrl_model

//--- verif/testbench.sv
// self-checking bench for the dram mode register bank
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic mrw, mrr, acc, bl32, apd, zqs, zql;
   logic [5:0] ma;
   logic [7:0] wd, rdd;
   logic [1:0] raw;
   logic rdv, dqs, b32, pst, wpre, rpre, read_postamble_length, zign, ftrim;
   int failures = 0;
   int checks = 0;
   int feat[2];
   int fwr, fop, odt, cterm, zq_resistor_selftest_result, err;
   logic [31:0] rnd = 32'hd84ed18a;
   int write_recovery_cycles[8] = '{6, 10, 16, 20, 24, 30, 34, 40};
   logic [5:0] ra[5] = '{6'h01, 6'h28, 6'h30, 6'h3f, 6'h0d};

   always #2.5 clk = ~clk;

   dmrb_top #(.REFRESH_MODIFIED_ONLY(1'b1), .BYTE_MODE_LATENCY(1'b0)) i_dut (
      .CLK_SYS(clk), .ARST_N(arst_n), .MRW_REQ(mrw), .MRR_REQ(mrr),
      .MR_ADDR(ma), .MRW_DATA(wd), .RD_VALID(rdv), .RD_DATA(rdd),
      .DQS_TOGGLE(dqs), .ACC_REQ(acc), .ACC_BL32(bl32), .WR_AP_DONE(apd),
      .BURST_32(b32), .PRECHARGE_START(pst), .WR_PREAMBLE_2NCK(wpre),
      .RD_PREAMBLE_TOGGLE(rpre), .RD_POSTAMBLE_LONG(read_postamble_length),
      .ZQ_START_DONE(zqs), .ZQ_LATCH_DONE(zql), .ZQ_SELFTEST_RAW(raw),
      .ZQ_CAL_IGNORE(zign), .FACTORY_TRIM_SEL(ftrim));
   dmrb_ctrl_model i_ctrl (.clk(clk), .mrw_req(mrw), .mrr_req(mrr),
      .mr_addr(ma), .mrw_data(wd), .acc_req(acc), .acc_bl32(bl32),
      .wr_ap_done(apd), .zq_start_done(zqs), .zq_latch_done(zql),
      .zq_selftest_raw(raw));

   // ----------
   // checking and reference model
   // ----------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
         input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp,
         input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask : chk_bit
   task automatic complete_run();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   function automatic logic [7:0] info();
      return {cterm == 1 && odt != 0, 2'h0, zq_resistor_selftest_result[1:0], 2'h0, 1'b1};
   endfunction : info
   task automatic do_reset();
      arst_n = 1'b0;
      feat = '{4, 4};
      {fwr, fop, odt, cterm, zq_resistor_selftest_result, err} = 192'h0;
      repeat (10) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
   endtask : do_reset
   task automatic mw(input logic [5:0] a, input logic [7:0] d);
      i_ctrl.cmd(6'h01, a, d, 1'b0);
      case (a)
         6'h01: feat[fwr] = d;
         6'h0b: odt = d[6:4];
         6'h0d: begin
            fop = d[7];
            fwr = d[6];
         end
         6'h16: cterm = d[5];
         default: ;
      endcase
   endtask : mw
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      i_ctrl.cmd(6'h02, a, 8'h00, 1'b0);
      chk_bit(rdv & dqs, 1'b1, "read strobe");
      v = rdd;
   endtask : rd
   task automatic chk_info();
      logic [7:0] v;
      rd(6'h00, v);
      chk_byte(v, info(), "device info");
   endtask : chk_info
   task automatic chk_ops();
      logic [7:0] f;
      f = 8'(feat[fop]);
      chk_bit(wpre, f[2], "wr preamble");
      chk_bit(rpre, f[3], "rd preamble");
      chk_bit(read_postamble_length, f[7], "postamble");
   endtask : chk_ops
   // result lands six cycles after the latch; one spare cycle for flags
   task automatic zq(input logic [1:0] r, input logic s);
      if (s) begin
         i_ctrl.cmd(6'h10, 6'h00, 8'h00, 1'b0);
         i_ctrl.idle();
      end
      i_ctrl.cmd(6'h20, 6'h00, {6'h00, r}, 1'b0);
      i_ctrl.idle();
      repeat (6) @(posedge clk);
      #1;
      if (s && err == 0) begin
         zq_resistor_selftest_result = r;
      end
      err = zq_resistor_selftest_result == 1 || zq_resistor_selftest_result == 2;
      chk_bit(zign, err[0], "zq ignore");
      chk_bit(ftrim, err[0], "factory trim");
      chk_info();
   endtask : zq

   // ----------
   // test sequence
   // ----------
   initial begin
      logic [7:0] v;
      int n;
      logic e;
      do_reset();
      chk_info();
      chk_ops();
      $display("test reset done");
      for (int j = 0; j < 5; j++) begin
         rd(ra[j], v);
      end
      mw(6'h00, 8'hff);
      chk_info();
      mw(6'h0b, 8'h10);
      chk_info();
      mw(6'h16, 8'h20);
      chk_info();
      mw(6'h0b, 8'h00);
      chk_info();
      $display("test info done");
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         mw(6'h0d, {rnd[1:0], 6'h00});
         mw(6'h01, {rnd[2], i[2:0], rnd[3], 1'b1, 2'(i % 3)});
         i_ctrl.idle();
         chk_ops();
         i_ctrl.cmd(6'h04, 6'h00, 8'h00, rnd[4]);
         v = 8'(feat[fop]);
         e = v[1:0] == 2'h2 ? rnd[4] : v[1:0] == 2'h1;
         chk_bit(b32, e, "bl");
         i_ctrl.cmd(6'h08, 6'h00, 8'h00, 1'b0);
         i_ctrl.idle();
         n = 1;
         while (pst !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
         end
         chk_byte(8'(n), 8'(write_recovery_cycles[v[6:4]]), "recovery");
      end
      $display("test features done");
      zq(2'h3, 1'b0);
      zq(2'h3, 1'b1);
      zq(2'h2, 1'b1);
      zq(2'h3, 1'b1);
      mw(6'h0d, 8'hc0);
      mw(6'h01, 8'hfe);
      i_ctrl.idle();
      chk_ops();
      i_ctrl.cmd(6'h04, 6'h00, 8'h00, 1'b1);
      chk_bit(b32, 1'b1, "bl per command");
      do_reset();
      chk_info();
      chk_ops();
      zq(2'h1, 1'b1);
      $display("test calibration done");
      complete_run();
   end

   // about sixty times the expected run
   initial begin
      #100000;
      failures++;
      complete_run();
   end
endmodule : testbench
